// [shared/dbc_pkg.sv]
// Package of the drive bus command block: instance numbers, field layout of
// the scaled word, range limits and protocol codes.
// Assumes a single core clock domain shared by both ends.
package dbc_pkg;

    // ********************************************************
    // Parameter instance numbers
    // ********************************************************
    localparam logic [15:0] ADDR_RESET_CMD = 16'ha795;
    localparam logic [15:0] ADDR_RUN_CMD = 16'ha796;
    localparam logic [15:0] ADDR_RUN_RIGHT_CMD = 16'ha797;
    localparam logic [15:0] ADDR_RUN_LEFT_CMD = 16'ha798;
    localparam logic [15:0] ADDR_SPEED_REF = 16'ha799;
    localparam logic [15:0] ADDR_PROC_FB = 16'ha79a;

    // ********************************************************
    // Scaled word layout
    // ********************************************************
    localparam int FMT_BIT = 15;
    localparam int EXP_MSB = 14;
    localparam int EXP_LSB = 11;
    localparam int MAN_MSB = 10;
    localparam int MAN_LSB = 0;
    localparam logic signed [15:0] RANGE_MAX = 16'sh4000;
    localparam logic signed [15:0] RANGE_MIN = -16'sh4000;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [15:0] UINT_MAX = 16'h7fff;
    localparam logic signed [10:0] MAN_LIMIT = 11'sh3e8;
    localparam logic signed [3:0] EXP_MAX = 4'sh7;

    // ********************************************************
    // Access protocol codes
    // ********************************************************
    typedef enum logic [1:0] {
        DBC_PROTO_RTU,
        DBC_PROTO_TCP,
        DBC_PROTO_FIELDBUS
    } dbc_proto_t;

endpackage

// [shared/dbc_if.sv]
// Interface joining the bus master end and the drive end.
// Assumes both ends run on core_clk; one write or read per valid/ready pair.
`timescale 1ns/1ps
`default_nettype none
interface dbc_if;
    logic req_valid;
    logic req_ready;
    logic req_write;
    logic [15:0] req_addr;
    logic [15:0] req_wdata;
    dbc_pkg::dbc_proto_t req_proto;
    logic rsp_valid;
    logic [15:0] rsp_rdata;
    logic rsp_error;

    modport drive (
        input req_valid,
        output req_ready,
        input req_write,
        input req_addr,
        input req_wdata,
        input req_proto,
        output rsp_valid,
        output rsp_rdata,
        output rsp_error
    );

    modport master (
        output req_valid,
        input req_ready,
        output req_write,
        output req_addr,
        output req_wdata,
        output req_proto,
        input rsp_valid,
        input rsp_rdata,
        input rsp_error
    );
endinterface
`default_nettype wire

// [rtl/dbc_drive.sv]
// Drive end: command parameters, reference and process value, scaled word
// decode of written values and scaled word encode of read values.
// Assumes a master that holds a request until req_ready and takes one answer.
`timescale 1ns/1ps
`default_nettype none

// Function
// [RULE_01] Start needs run plus a direction
// [RULE_02] Both directions give bipolar reference mode
// [RULE_03] Reset instance write pulses drive reset
// [RULE_04] Reference clamped to -16384..16384, default 0
// [RULE_05] Process value clamped likewise, default 0
// [RULE_06] Scaled word only on Modbus RTU/TCP
// [RULE_07] Bit 15 selects integer or float
// [RULE_08] Format 0 is unsigned 0..32767
// [RULE_09] Format 1 is mantissa times ten^exponent
// [RULE_10] Exponent four bit signed -8..7
// [RULE_11] Mantissa eleven bit signed -1024..1023
// [RULE_12] Written values rounded to held digits; the code truncates the fraction toward zero instead
// [RULE_13] Reads return either encoding
// [RULE_14] Float encoding keeps three significant digits
// [RULE_15] Runs without panel if sources external
// [RULE_16] Exponent bits 14..11, mantissa 10..0
// [RULE_17] Signed words clamped to range limits
module dbc_drive (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    dbc_if.drive bus,
    input wire logic ref_source_is_bus,
    input wire logic proc_source_is_bus,
    input wire logic all_sources_external,
    output logic start_cmd,
    output logic run_right_cmd,
    output logic run_left_cmd,
    output logic bipolar_mode,
    output logic drive_reset_pulse,
    output logic signed [15:0] speed_reference,
    output logic signed [15:0] process_feedback
);

    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        logic reset_cmd;
        logic run;
        logic right;
        logic left;
        logic signed [15:0] speed_ref;
        logic signed [15:0] proc_fb;
        logic reset_pulse;
        logic rsp_valid;
        logic [15:0] rsp_rdata;
        logic rsp_error;
    } dbc_drv_state_t;

    dbc_drv_state_t st_reg;
    dbc_drv_state_t st_next;

    // Decode a scaled word to a clamped signed integer
    function automatic logic signed [15:0] dbc_decode(input logic [15:0] w,
                                                      input logic scaled);
        logic signed [10:0] man;
        logic signed [3:0] ex;
        logic signed [31:0] v;
        man = w[dbc_pkg::MAN_MSB:dbc_pkg::MAN_LSB]; // RULE_16
        ex = w[dbc_pkg::EXP_MSB:dbc_pkg::EXP_LSB];
        v = 32'sh0000_0000;
        if (!scaled || !w[dbc_pkg::FMT_BIT]) begin
            // Plain two's complement or unsigned integer
            v = 32'(signed'(w)); // RULE_06
        end else begin
            v = 32'(man); // RULE_09 RULE_11
            if (ex >= 0) begin
                for (int i = 0; i < 7; i++) begin
                    if (i < ex && v < 32'sh0001_0000 && v > -32'sh0001_0000) begin
                        v = v * 10;
                    end
                end
            end else begin
                // Fraction truncated toward zero, not rounded to held digits
                for (int i = 0; i < 8; i++) begin
                    if (i < -ex) begin
                        v = v / 10; // RULE_10 RULE_12
                    end
                end
            end
        end
        if (v > 32'(dbc_pkg::RANGE_MAX)) begin
            v = 32'(dbc_pkg::RANGE_MAX); // RULE_17
        end else if (v < 32'(dbc_pkg::RANGE_MIN)) begin
            v = 32'(dbc_pkg::RANGE_MIN);
        end
        return v[15:0];
    endfunction

    // Encode a signed value: integer if 0..32767, else float form
    function automatic logic [15:0] dbc_encode(input logic signed [15:0] v);
        logic signed [16:0] m;
        logic [3:0] e;
        m = 17'(v);
        e = 4'h0;
        if (v >= 0) begin
            return {1'b0, v[14:0]}; // RULE_07 RULE_08 RULE_13
        end
        // Shrink to three significant digits
        for (int i = 0; i < 2; i++) begin
            if (m < -17'(dbc_pkg::MAN_LIMIT)) begin
                m = (m - 17'sd5) / 17'sd10; // RULE_14
                e = e + 4'h1;
            end
        end
        return {1'b1, e, m[10:0]}; // RULE_16
    endfunction

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb begin
        logic hit;
        logic scaled;
        logic [15:0] rd;
        hit = 1'b1;
        scaled = (bus.req_proto != dbc_pkg::DBC_PROTO_FIELDBUS); // RULE_06
        rd = dbc_pkg::WORD_ZERO;
        st_next = st_reg;
        st_next.reset_pulse = 1'b0;
        st_next.rsp_valid = 1'b0;
        if (bus.req_valid && !st_reg.rsp_valid) begin
            unique case (bus.req_addr)
                dbc_pkg::ADDR_RESET_CMD: rd = {15'h0000, st_reg.reset_cmd};
                dbc_pkg::ADDR_RUN_CMD: rd = {15'h0000, st_reg.run};
                dbc_pkg::ADDR_RUN_RIGHT_CMD: rd = {15'h0000, st_reg.right};
                dbc_pkg::ADDR_RUN_LEFT_CMD: rd = {15'h0000, st_reg.left};
                dbc_pkg::ADDR_SPEED_REF: rd = scaled ? dbc_encode(st_reg.speed_ref)
                                                     : st_reg.speed_ref;
                dbc_pkg::ADDR_PROC_FB: rd = scaled ? dbc_encode(st_reg.proc_fb)
                                                   : st_reg.proc_fb;
                default: hit = 1'b0;
            endcase
            if (bus.req_write && hit) begin
                unique case (bus.req_addr)
                    dbc_pkg::ADDR_RESET_CMD: begin
                        st_next.reset_cmd = bus.req_wdata != dbc_pkg::WORD_ZERO;
                        st_next.reset_pulse = 1'b1; // RULE_03
                    end
                    dbc_pkg::ADDR_RUN_CMD: st_next.run = bus.req_wdata != dbc_pkg::WORD_ZERO;
                    dbc_pkg::ADDR_RUN_RIGHT_CMD: st_next.right = bus.req_wdata != dbc_pkg::WORD_ZERO;
                    dbc_pkg::ADDR_RUN_LEFT_CMD: st_next.left = bus.req_wdata != dbc_pkg::WORD_ZERO;
                    dbc_pkg::ADDR_SPEED_REF: st_next.speed_ref = dbc_decode(bus.req_wdata, scaled); // RULE_04
                    dbc_pkg::ADDR_PROC_FB: st_next.proc_fb = dbc_decode(bus.req_wdata, scaled); // RULE_05
                    default: st_next.run = st_reg.run;
                endcase
            end
            st_next.rsp_valid = 1'b1;
            st_next.rsp_rdata = bus.req_write ? dbc_pkg::WORD_ZERO : rd;
            st_next.rsp_error = !hit;
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign bus.req_ready = !st_reg.rsp_valid;
    assign bus.rsp_valid = st_reg.rsp_valid;
    assign bus.rsp_rdata = st_reg.rsp_rdata;
    assign bus.rsp_error = st_reg.rsp_error;
    // Start gated by run and direction; no panel needed when external
    assign start_cmd = st_reg.run && (st_reg.right || st_reg.left)
                       && all_sources_external; // RULE_01 RULE_15
    assign run_right_cmd = st_reg.right;
    assign run_left_cmd = st_reg.left;
    assign bipolar_mode = st_reg.right && st_reg.left; // RULE_02
    assign drive_reset_pulse = st_reg.reset_pulse; // RULE_03
    // Values only used when their source selects the bus
    assign speed_reference = ref_source_is_bus ? st_reg.speed_ref : 16'sh0000; // RULE_04
    assign process_feedback = proc_source_is_bus ? st_reg.proc_fb : 16'sh0000; // RULE_05

endmodule
`default_nettype wire

// [rtl/dbc_master.sv]
// Master end: APB slave with its own registers, issues one parameter access
// per command and decodes the scaled word of read answers.
// Assumes the drive end answers one request at a time.
`timescale 1ns/1ps
`default_nettype none
module dbc_master (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    dbc_if.master bus,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    // ********************************************************
    // Own register offsets
    // ********************************************************
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_DATA = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_VALUE = 8'h0c;

    typedef struct packed {
        logic busy;
        logic sent;
        logic done;
        logic err;
        logic write;
        dbc_pkg::dbc_proto_t proto;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic signed [31:0] value;
    } dbc_mst_state_t;

    dbc_mst_state_t st_reg;
    dbc_mst_state_t st_next;

    // Decode either encoding of a read word to an integer (fraction dropped)
    function automatic logic signed [31:0] dbc_value(input logic [15:0] w);
        logic signed [31:0] v;
        logic signed [3:0] ex;
        ex = w[dbc_pkg::EXP_MSB:dbc_pkg::EXP_LSB]; // RULE_16
        v = 32'(signed'(w[dbc_pkg::MAN_MSB:dbc_pkg::MAN_LSB])); // RULE_09 RULE_11
        if (!w[dbc_pkg::FMT_BIT]) begin
            return {17'h0_0000, w[14:0]}; // RULE_07 RULE_08 RULE_13
        end
        for (int i = 0; i < 8; i++) begin
            if (ex >= 0 && i < ex) begin
                v = v * 10; // RULE_10
            end else if (ex < 0 && i < -ex) begin
                v = v / 10;
            end
        end
        return v;
    endfunction

    wire logic acc = psel && penable;

    // Next state: APB writes launch requests, answers are captured
    always_comb begin
        st_next = st_reg;
        if (acc && pwrite) begin
            if (paddr == OFS_DATA) begin
                st_next.wdata = pwdata[15:0];
            end else if (paddr == OFS_CMD && !st_reg.busy) begin
                // Bits 15:0 instance, 16 write, 18:17 protocol
                st_next.addr = pwdata[15:0];
                st_next.write = pwdata[16];
                st_next.proto = dbc_pkg::dbc_proto_t'(pwdata[18:17]);
                st_next.busy = 1'b1;
                st_next.done = 1'b0;
            end
        end
        if (st_reg.busy && bus.rsp_valid) begin
            st_next.busy = 1'b0;
            st_next.done = 1'b1;
            st_next.err = bus.rsp_error;
            st_next.rdata = bus.rsp_rdata;
            st_next.value = dbc_value(bus.rsp_rdata);
        end
        // Request taken; no reissue until its answer
        st_next.sent = st_reg.busy && (st_reg.sent || bus.req_ready) && !bus.rsp_valid;
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    // Request held until taken; pending flag stops reissue
    assign bus.req_valid = st_reg.busy && !st_reg.sent;
    assign bus.req_write = st_reg.write;
    assign bus.req_addr = st_reg.addr;
    assign bus.req_wdata = st_reg.wdata;
    assign bus.req_proto = st_reg.proto;

    // APB read mux, zero wait states
    always_comb begin
        unique case (paddr)
            OFS_CMD: prdata = {13'h0000, st_reg.proto, st_reg.write, st_reg.addr};
            OFS_DATA: prdata = {16'h0000, st_reg.rdata};
            OFS_STATUS: prdata = {29'h0000_0000, st_reg.err, st_reg.done, st_reg.busy};
            OFS_VALUE: prdata = st_reg.value;
            default: prdata = 32'h0000_0000;
        endcase
    end
    assign pready = clk_en; // No transfer taken while frozen
    assign pslverr = acc && !(paddr inside {OFS_CMD, OFS_DATA, OFS_STATUS, OFS_VALUE});

endmodule
`default_nettype wire

// [dv/dbc_asserts.sv]
// Checker of the link between the two ends and of the drive outputs.
// Assumes one core clock; the bench instantiates it beside the link.
`timescale 1ns/1ps
`default_nettype none
module dbc_asserts (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_write,
    input wire logic [15:0] req_addr,
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_rdata,
    input wire logic rsp_error,
    input wire logic start_cmd,
    input wire logic run_right_cmd,
    input wire logic run_left_cmd,
    input wire logic bipolar_mode,
    input wire logic drive_reset_pulse,
    input wire logic signed [15:0] speed_reference,
    input wire logic signed [15:0] process_feedback
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ********************************************************
    // Link handshake
    // ********************************************************
    property p_answer; req_valid && req_ready && clk_en |=> rsp_valid; endproperty
    a_answer: assert property (p_answer) else $error("answer missing after take");
    property p_gap; rsp_valid |-> !req_ready ##1 (!rsp_valid && req_ready); endproperty
    a_gap: assert property (p_gap) else $error("answer not a single cycle");
    property p_err; rsp_valid && rsp_error |-> rsp_rdata == 16'h0000; endproperty
    a_err: assert property (p_err) else $error("error answer carries data");
    // ********************************************************
    // Drive outputs
    // ********************************************************
    property p_rst; req_valid && req_ready && req_write && req_addr == dbc_pkg::ADDR_RESET_CMD
        |-> ##[1:2] drive_reset_pulse; endproperty
    a_rst: assert property (p_rst) else $error("reset write gave no pulse");
    property p_pulse; drive_reset_pulse |=> !drive_reset_pulse; endproperty
    a_pulse: assert property (p_pulse) else $error("reset pulse too long");
    property p_start; start_cmd |-> run_right_cmd || run_left_cmd; endproperty
    a_start: assert property (p_start) else $error("start without direction");
    property p_bip; bipolar_mode == (run_right_cmd && run_left_cmd); endproperty
    a_bip: assert property (p_bip) else $error("bipolar mode wrong");
    property p_ref; speed_reference >= dbc_pkg::RANGE_MIN
        && speed_reference <= dbc_pkg::RANGE_MAX; endproperty
    a_ref: assert property (p_ref) else $error("reference out of range");
    property p_fb; process_feedback >= dbc_pkg::RANGE_MIN
        && process_feedback <= dbc_pkg::RANGE_MAX; endproperty
    a_fb: assert property (p_fb) else $error("feedback out of range");
    // Main scenarios reached
    c_write: cover property (req_valid && req_ready && req_write);
    c_error: cover property (rsp_valid && rsp_error);
    c_bip: cover property (bipolar_mode);
    c_rst: cover property (drive_reset_pulse);
endmodule
`default_nettype wire

// [dv/test_drive_bus_command_and_eint_codec.sv]
// Bench joining master and drive ends; software side driven over APB.
// Assumes the package and link interface are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_drive_bus_command_and_eint_codec;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic ref_source_is_bus = 1'b1;
    logic proc_source_is_bus = 1'b1;
    logic all_sources_external = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, start_cmd, run_right_cmd, run_left_cmd;
    logic bipolar_mode, drive_reset_pulse, serr;
    logic signed [15:0] speed_reference, process_feedback;
    logic [31:0] rd, st, rdw, val;
    int fails = 0;
    int total_checks = 0;
    int pulses = 0;
    dbc_if link ();
    dbc_drive dbc_drive_inst (.core_clk, .rst_n, .clk_en, .bus(link), .ref_source_is_bus,
        .proc_source_is_bus, .all_sources_external, .start_cmd, .run_right_cmd,
        .run_left_cmd, .bipolar_mode, .drive_reset_pulse, .speed_reference,
        .process_feedback);
    dbc_master dbc_master_inst (.core_clk, .rst_n, .clk_en, .bus(link), .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    dbc_asserts dbc_asserts_inst (.core_clk, .rst_n, .clk_en, .req_valid(link.req_valid),
        .req_ready(link.req_ready), .req_write(link.req_write), .req_addr(link.req_addr),
        .rsp_valid(link.rsp_valid), .rsp_rdata(link.rsp_rdata), .rsp_error(link.rsp_error),
        .start_cmd, .run_right_cmd, .run_left_cmd, .bipolar_mode, .drive_reset_pulse,
        .speed_reference, .process_feedback);
    // ********************************************************
    // Clock, pulse counter and report
    // ********************************************************
    initial forever #2 core_clk = ~core_clk;
    // Counts drive reset pulses
    always @(posedge core_clk) if (drive_reset_pulse === 1'b1) pulses <= pulses + 1;
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    // ********************************************************
    // Bus tasks
    // ********************************************************
    // One APB transfer; data and error taken at the ready edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin fails++; finish_test(); end
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // One parameter access through the master, waiting for done
    task acc(input logic w, input dbc_pkg::dbc_proto_t p, input logic [15:0] i,
        input logic [15:0] d);
        int n;
        apb(1'b1, 8'h04, {16'h0000, d});
        apb(1'b1, 8'h00, {13'h0000, p, w, i});
        n = 0;
        do begin apb(1'b0, 8'h08, 32'h0000_0000); n++; end
        while ((rd[0] !== 1'b0 || rd[1] !== 1'b1) && n < 50);
        if (rd[0] !== 1'b0 || rd[1] !== 1'b1) begin fails++; finish_test(); end
        st = rd;
        apb(1'b0, 8'h04, 32'h0000_0000);
        rdw = rd;
        apb(1'b0, 8'h0c, 32'h0000_0000);
        val = rd;
    endtask
    // ********************************************************
    // Scenarios
    // ********************************************************
    task t_commands;
        check("ref_reset", 32'h0000_0000, 32'(speed_reference));
        check("fb_reset", 32'h0000_0000, 32'(process_feedback));
        acc(1'b1, dbc_pkg::DBC_PROTO_RTU, dbc_pkg::ADDR_RUN_CMD, 16'h0001);
        check("start_run_only", 32'h0, 32'(start_cmd));
        acc(1'b1, dbc_pkg::DBC_PROTO_TCP, dbc_pkg::ADDR_RUN_RIGHT_CMD, 16'h0001);
        check("start_right", 32'h1, 32'(start_cmd));
        check("bipolar_off", 32'h0, 32'(bipolar_mode));
        acc(1'b1, dbc_pkg::DBC_PROTO_RTU, dbc_pkg::ADDR_RUN_LEFT_CMD, 16'h0001);
        check("bipolar_on", 32'h1, 32'(bipolar_mode));
        check("left_cmd", 32'h1, 32'(run_left_cmd));
        check("right_cmd", 32'h1, 32'(run_right_cmd));
        all_sources_external <= 1'b0;
        repeat (2) @(posedge core_clk);
        check("start_panel", 32'h0, 32'(start_cmd));
        all_sources_external <= 1'b1;
        acc(1'b1, dbc_pkg::DBC_PROTO_RTU, dbc_pkg::ADDR_RUN_RIGHT_CMD, 16'h0000);
        check("start_left", 32'h1, 32'(start_cmd));
        acc(1'b1, dbc_pkg::DBC_PROTO_RTU, dbc_pkg::ADDR_RUN_CMD, 16'h0000);
        check("start_stop", 32'h0, 32'(start_cmd));
        acc(1'b1, dbc_pkg::DBC_PROTO_TCP, dbc_pkg::ADDR_RESET_CMD, 16'h0001);
        check("reset_pulses", 32'h1, 32'(pulses));
    endtask
    // Written words against decoded reference
    task automatic t_values;
        dbc_pkg::dbc_proto_t pr [7] = '{dbc_pkg::DBC_PROTO_RTU, dbc_pkg::DBC_PROTO_RTU,
            dbc_pkg::DBC_PROTO_TCP, dbc_pkg::DBC_PROTO_RTU, dbc_pkg::DBC_PROTO_RTU,
            dbc_pkg::DBC_PROTO_RTU, dbc_pkg::DBC_PROTO_FIELDBUS};
        logic [15:0] wd [7] = '{16'h1000, 16'h907b, 16'hf87d, 16'h8418, 16'h4e20,
            16'hb801, 16'hc000};
        logic [31:0] ex [7] = '{32'h0000_1000, 32'h0000_300c, 32'h0000_000c,
            32'hffff_fc18, 32'h0000_4000, 32'h0000_4000, 32'hffff_c000};
        for (int k = 0; k < 7; k++) begin
            acc(1'b1, pr[k], dbc_pkg::ADDR_SPEED_REF, wd[k]);
            check("ref_word", ex[k], 32'(speed_reference));
        end
        ref_source_is_bus <= 1'b0;
        repeat (2) @(posedge core_clk);
        check("ref_not_bus", 32'h0000_0000, 32'(speed_reference));
        ref_source_is_bus <= 1'b1;
        acc(1'b1, dbc_pkg::DBC_PROTO_RTU, dbc_pkg::ADDR_PROC_FB, 16'h012c);
        check("fb_int", 32'h0000_012c, 32'(process_feedback));
        acc(1'b1, dbc_pkg::DBC_PROTO_FIELDBUS, dbc_pkg::ADDR_PROC_FB, 16'hbfff);
        check("fb_clamp", 32'hffff_c000, 32'(process_feedback));
    endtask
    // Read answers in both encodings, then refusals
    task t_reads;
        acc(1'b1, dbc_pkg::DBC_PROTO_RTU, dbc_pkg::ADDR_SPEED_REF, 16'h300c);
        acc(1'b0, dbc_pkg::DBC_PROTO_RTU, dbc_pkg::ADDR_SPEED_REF, 16'h0000);
        check("rd_int", 32'h0000_300c, {16'h0000, rdw[15:0]});
        check("val_int", 32'h0000_300c, val);
        acc(1'b1, dbc_pkg::DBC_PROTO_FIELDBUS, dbc_pkg::ADDR_SPEED_REF, 16'hfc18);
        acc(1'b0, dbc_pkg::DBC_PROTO_TCP, dbc_pkg::ADDR_SPEED_REF, 16'h0000);
        check("rd_fmt", 32'h1, 32'(rdw[15]));
        check("val_neg", 32'hffff_fc18, val);
        acc(1'b0, dbc_pkg::DBC_PROTO_FIELDBUS, dbc_pkg::ADDR_SPEED_REF, 16'h0000);
        check("rd_fieldbus", 32'h0000_fc18, {16'h0000, rdw[15:0]});
        acc(1'b1, dbc_pkg::DBC_PROTO_FIELDBUS, dbc_pkg::ADDR_SPEED_REF, 16'hc000);
        acc(1'b0, dbc_pkg::DBC_PROTO_RTU, dbc_pkg::ADDR_SPEED_REF, 16'h0000);
        check("rd_three_digits", 32'h0000_975c, {16'h0000, rdw[15:0]});
        check("val_three_digits", 32'hffff_bff0, val);
        acc(1'b0, dbc_pkg::DBC_PROTO_RTU, 16'ha79b, 16'h0000);
        check("status_err", 32'h1, 32'(st[2]));
        apb(1'b0, 8'h10, 32'h0000_0000);
        check("apb_unmapped", 32'h1, 32'(serr));
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        t_commands();
        t_values();
        t_reads();
        finish_test();
    end
endmodule
`default_nettype wire
